// [rtl/dsc_top.sv]
// Purpose: Control, configuration and status of a link deserializer.
// Assumes: Pins are asynchronous; test_error and pixel_mhz are on mclk.
// Notes: Pin levels pass the synchroniser before any use.
// Notes on behaviour
// - Locked: output enable alone decides whether lanes carry data.
// - Unlocked: sleep-state select and output enable together decide lanes.
// - Power-down input high runs the device; low default keeps it off.
// - Power-down input low stops all link and output activity.
// - While powered down the PLL is off and control registers reset.
// - Swing select by pin or register: high large, low small swing.
// - Band select by pin or register: high low band, low high band.
// - No spreading when pixel clock is above the upper limit.
// - Bit-order select: high puts MSBs on lane three, low LSBs.
// - Mode 00 and 01 are native; 01 also enables control filter.
// - Mode 10 and 11 select two different older serializers.
// - Mode comes from pins; registers may only change the filter.
// - Three-bit select chooses the spreading range of the clock.
// - Strap high enables high input gain, low leaves gain minimal.
// - Self-test enable high turns the link test on; default off.
// - During test, result is high until an error is detected.
`timescale 1ns/1ps
`default_nettype none
module dsc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire dsc_pkg::dsc_pins_t pins,
  input wire logic test_error,
  input wire logic [7:0] pixel_mhz,
  input wire dsc_pkg::dsc_bus_t bus,
  output logic [dsc_pkg::DATA_W-1:0] rdata,
  output var dsc_pkg::dsc_ctl_t ctl,
  output logic pass_out,
  output logic pass_oe_n,
  output logic irq
);

  import dsc_pkg::*;

  logic [1:0] rst_sync_reg;
  wire rst_n;
  dsc_pins_t pin_s;
  dsc_pwr_t pwr_reg;
  dsc_pwr_t pwr_next;
  logic [DATA_W-1:0] ctrl_reg;
  logic [3:0] range_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] istat_reg;
  logic [IRQ_W-1:0] istat_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rd_mux;
  logic gain_reg;
  logic pass_reg;
  logic pass_oe_n_reg;
  logic lock_prev_reg;
  logic irq_reg;
  dsc_ctl_t ctl_reg;
  dsc_ctl_t ctl_next;

  // Reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  dsc_sync #(
    .W($bits(dsc_pins_t))
  ) u_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d(pins),
    .q(pin_s)
  );

  // Power sequencing: the strap is taken in the one cycle of PS_STRAP
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PS_OFF: begin
        if (pin_s.power_down_n) begin
          pwr_next = PS_STRAP;
        end
      end
      PS_STRAP: begin
        pwr_next = pin_s.power_down_n ? PS_RUN : PS_OFF;
      end
      PS_RUN: begin
        if (!pin_s.power_down_n) begin
          pwr_next = PS_OFF;
        end
      end
      default: begin
        pwr_next = PS_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= PS_OFF;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  wire powered = pwr_reg != PS_OFF;
  wire running = pwr_reg == PS_RUN;
  wire strap_take = pwr_reg == PS_STRAP;

  // Register decode; writes are ignored while powered down
  wire hit_ctrl = bus.addr == OFS_CTRL;
  wire hit_stat = bus.addr == OFS_STAT;
  wire hit_istat = bus.addr == OFS_ISTAT;
  wire hit_imask = bus.addr == OFS_IMASK;
  wire hit_range = bus.addr == OFS_RANGE;
  wire wr_ok = bus.wr && powered;
  wire wr_ctrl = wr_ok && hit_ctrl;
  wire wr_istat = wr_ok && hit_istat;
  wire wr_imask = wr_ok && hit_imask;
  wire wr_range = wr_ok && hit_range;

  // Control registers return to defaults while powered down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      range_reg <= RANGE_RST;
      imask_reg <= IMASK_RST;
    end else if (!powered) begin
      ctrl_reg <= CTRL_RST;
      range_reg <= RANGE_RST;
      imask_reg <= IMASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= bus.wdata;
      end
      if (wr_range) begin
        range_reg <= bus.wdata[3:0];
      end
      if (wr_imask) begin
        imask_reg <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  // Effective settings: register override wins over the pin
  wire swing_eff = ctrl_reg[C_SWING_OV] ? ctrl_reg[C_SWING]
                                        : pin_s.output_swing_select;
  wire band_eff = ctrl_reg[C_BAND_OV] ? ctrl_reg[C_BAND]
                                      : pin_s.low_band_select;
  wire map_eff = ctrl_reg[C_MAP_OV] ? ctrl_reg[C_MAP]
                                    : pin_s.bit_order_select;
  wire [2:0] range_eff = range_reg[R_OV] ? range_reg[2:0]
                                         : pin_s.spread_range_select;

  // Older-serializer modes are pin only; register touches only the filter
  wire filt_bit = ctrl_reg[C_FILT_OV] ? ctrl_reg[C_FILT]
                                      : pin_s.mode_pins[0];
  wire [1:0] mode_bits = pin_s.mode_pins[1] ? pin_s.mode_pins
                                            : {1'b0, filt_bit};

  wire lock_now = powered && pin_s.pll_lock;
  wire oe_pin = pin_s.output_enable_pin;
  wire freq_ok = pixel_mhz <= SSC_MAX_MHZ;
  wire st_active = running && pin_s.self_test_enable;

  always_comb begin
    ctl_next.pll_enable = powered;
    ctl_next.lock = lock_now;
    ctl_next.lanes_data = lock_now && oe_pin;
    ctl_next.lanes_drive = powered && oe_pin &&
                           (lock_now || pin_s.sleep_state_select);
    ctl_next.swing_large = swing_eff;
    ctl_next.low_band_setting = band_eff;
    ctl_next.ssc_enable = powered && freq_ok &&
                          (range_eff != RANGE_OFF);
    ctl_next.spread_range = range_eff;
    ctl_next.msb_on_lane_three = map_eff;
    ctl_next.mode = dsc_mode_t'(mode_bits);
    ctl_next.ctl_filter = mode_bits == MODE_NATIVE_FILT;
    ctl_next.input_gain_boost = gain_reg;
    ctl_next.self_test_active = st_active;
  end

  // Strap capture before the shared pin turns into an output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= 1'b0;
    end else if (!powered) begin
      gain_reg <= 1'b0;
    end else if (strap_take) begin
      gain_reg <= pin_s.strap_level;
    end
  end

  // Test result: high on entry, dropped by the first error
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pass_reg <= 1'b1;
      pass_oe_n_reg <= 1'b1;
    end else begin
      pass_oe_n_reg <= !st_active;
      if (!st_active) begin
        pass_reg <= 1'b1;
      end else if (test_error) begin
        pass_reg <= 1'b0;
      end
    end
  end

  // Events; a set in the same cycle as its clear wins
  wire [IRQ_W-1:0] events = {strap_take,
                             st_active && test_error && pass_reg,
                             lock_prev_reg && !lock_now,
                             lock_now && !lock_prev_reg};
  wire [IRQ_W-1:0] clr_bits = wr_istat ? bus.wdata[IRQ_W-1:0]
                                       : ISTAT_RST;

  always_comb begin
    istat_next = (istat_reg & ~clr_bits) | events;
    if (!powered) begin
      istat_next = ISTAT_RST;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= ISTAT_RST;
      lock_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      lock_prev_reg <= lock_now;
      irq_reg <= |(istat_next & imask_reg);
    end
  end

  // Read path: data in the cycle after the strobe only
  wire [DATA_W-1:0] stat_word = {pass_reg, st_active, gain_reg,
                                 ctl_reg.ssc_enable, mode_bits,
                                 powered, lock_now};
  assign rd_mux = hit_ctrl ? ctrl_reg :
                  hit_stat ? stat_word :
                  hit_istat ? {4'h0, istat_reg} :
                  hit_imask ? {4'h0, imask_reg} :
                  hit_range ? {4'h0, range_reg} : RD_ZERO;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RD_ZERO;
      ctl_reg <= '0;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : RD_ZERO;
      ctl_reg <= ctl_next;
    end
  end

  assign rdata = rdata_reg;
  assign ctl = ctl_reg;
  assign pass_out = pass_reg;
  assign pass_oe_n = pass_oe_n_reg;
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wake;
    pwr_reg == PS_OFF && pin_s.power_down_n;
  endsequence

  sequence s_strap_run;
    pwr_reg == PS_STRAP ##1 pwr_reg == PS_RUN;
  endsequence

  sequence s_pdn;
    !pin_s.power_down_n;
  endsequence

  lock_gate_a: assert property (
    lock_now && oe_pin |=> ctl_reg.lanes_data && ctl_reg.lanes_drive)
    else $error("locked lanes not enabled");

  unlock_lanes_a: assert property (
    powered && !lock_now |=> !ctl_reg.lanes_data &&
      ctl_reg.lanes_drive == $past(oe_pin && pin_s.sleep_state_select))
    else $error("unlocked lane state wrong");

  wake_seq_a: assert property (
    s_wake ##1 pin_s.power_down_n |-> s_strap_run)
    else $error("power-up sequence wrong");

  pdn_stop_a: assert property (
    s_pdn |=> pwr_reg == PS_OFF ##1
      !ctl_reg.pll_enable && !ctl_reg.lanes_drive && pass_oe_n)
    else $error("power-down did not stop outputs");

  reg_clear_a: assert property (
    pwr_reg == PS_OFF |=> ctrl_reg == CTRL_RST &&
      imask_reg == IMASK_RST && range_reg == RANGE_RST)
    else $error("registers not reset in power-down");

  swing_ovr_a: assert property (
    ctrl_reg[C_SWING_OV] |=> ctl_reg.swing_large == $past(ctrl_reg[C_SWING]))
    else $error("swing override ignored");

  band_pin_a: assert property (
    !ctrl_reg[C_BAND_OV] |=>
      ctl_reg.low_band_setting == $past(pin_s.low_band_select))
    else $error("band select not from pin");

  ssc_limit_a: assert property (
    pixel_mhz > SSC_MAX_MHZ |=> !ctl_reg.ssc_enable)
    else $error("spreading above limit");

  map_sel_a: assert property (
    ctl_reg.msb_on_lane_three == $past(map_eff))
    else $error("bit order wrong");

  filt_mode_a: assert property (
    ctl_reg.ctl_filter == (ctl_reg.mode == MODE_NATIVE_FILT))
    else $error("filter not tied to mode");

  legacy_pin_a: assert property (
    pin_s.mode_pins[1] |=> ctl_reg.mode == $past(pin_s.mode_pins))
    else $error("legacy mode overridden");

  mode_limit_a: assert property (
    !pin_s.mode_pins[1] |=> !ctl_reg.mode[1])
    else $error("register reached legacy mode");

  range_sel_a: assert property (
    !range_reg[R_OV] |=>
      ctl_reg.spread_range == $past(pin_s.spread_range_select))
    else $error("range not from pin");

  strap_take_a: assert property (
    strap_take |=> gain_reg == $past(pin_s.strap_level) && pass_oe_n
      ##1 ctl_reg.input_gain_boost == $past(gain_reg))
    else $error("strap not captured");

  test_off_a: assert property (
    !pin_s.self_test_enable |=> pass_oe_n && !ctl_reg.self_test_active)
    else $error("test active without enable");

  pass_drop_a: assert property (
    st_active && test_error |=>
      !pass_reg ##1 (!pass_reg || !$past(st_active)))
    else $error("result not dropped on error");

  set_wins_a: assert property (
    powered && events[I_ERR] && wr_istat && bus.wdata[I_ERR]
      |=> istat_reg[I_ERR])
    else $error("event lost on clear");

endmodule : dsc_top
`default_nettype wire

// [rtl/dsc_pkg.sv]
// Purpose: Shared constants and types of the deserializer control block.
// Assumes: 8-bit register port with a 4-bit address.
// Notes: Offsets, field positions and reset values live only here.
package dsc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RANGE = 4'h4;

  // Control register fields
  localparam int C_SWING_OV = 0;
  localparam int C_SWING = 1;
  localparam int C_BAND_OV = 2;
  localparam int C_BAND = 3;
  localparam int C_MAP_OV = 4;
  localparam int C_MAP = 5;
  localparam int C_FILT_OV = 6;
  localparam int C_FILT = 7;

  // Range override register fields
  localparam int R_OV = 3;

  // Interrupt status bits
  localparam int I_LOCK_UP = 0;
  localparam int I_LOCK_DN = 1;
  localparam int I_ERR = 2;
  localparam int I_STRAP = 3;

  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
  localparam logic [IRQ_W-1:0] ISTAT_RST = 4'h0;
  localparam logic [3:0] RANGE_RST = 4'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

  localparam logic [2:0] RANGE_OFF = 3'h0;
  // Highest pixel clock, in MHz, at which spreading is offered
  localparam logic [7:0] SSC_MAX_MHZ = 8'h41;

  typedef enum logic [1:0] {
    MODE_NATIVE = 2'b00,
    MODE_NATIVE_FILT = 2'b01,
    MODE_LEGACY_A = 2'b10,
    MODE_LEGACY_B = 2'b11
  } dsc_mode_t;

  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_STRAP = 2'b01,
    PS_RUN = 2'b10
  } dsc_pwr_t;

  typedef struct packed {
    logic power_down_n;
    logic pll_lock;
    logic output_swing_select;
    logic output_enable_pin;
    logic sleep_state_select;
    logic low_band_select;
    logic bit_order_select;
    logic [1:0] mode_pins;
    logic [2:0] spread_range_select;
    logic self_test_enable;
    logic strap_level;
  } dsc_pins_t;

  typedef struct packed {
    logic pll_enable;
    logic lock;
    logic lanes_drive;
    logic lanes_data;
    logic swing_large;
    logic ssc_enable;
    logic low_band_setting;
    logic [2:0] spread_range;
    logic msb_on_lane_three;
    dsc_mode_t mode;
    logic ctl_filter;
    logic input_gain_boost;
    logic self_test_active;
  } dsc_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dsc_bus_t;

endpackage : dsc_pkg

// [rtl/dsc_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : dsc_sync
`default_nettype wire

// [tb/dsc_link_model.sv]
// Purpose: Behavioural companion serializer seen from the link side.
// Assumes: Lock and error indications arrive on mclk.
// Notes: Lock comes LOCK_DLY+1 cycles after link_on, drops at once.
`timescale 1ns/1ps
`default_nettype none
module dsc_link_model #(
  parameter int LOCK_DLY = 4
) (
  input wire logic mclk,
  input wire logic link_on,
  input wire logic inject_err,
  output logic lock,
  output logic err
);
  int cnt;
  always_ff @(posedge mclk) begin
    if (!link_on) begin
      cnt <= 0;
      lock <= 1'b0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end else begin
      lock <= 1'b1;
    end
    // One bit error for each cycle of the request
    err <= inject_err;
  end
endmodule : dsc_link_model
`default_nettype wire

// [tb/test_deser_control_config.sv]
// Purpose: Self-checking bench of the deserializer control block.
// Assumes: Pins settle within six clocks of a change.
// Notes: The shared strap pin reads the pass output while it is driven.
`timescale 1ns/1ps
`default_nettype none
module test_deser_control_config;
  import dsc_pkg::*;
  logic mclk, arst_n, err_w, lock_w, link_on, inject;
  dsc_pins_t pin_r, pin_w;
  logic [7:0] pixel_mhz;
  dsc_bus_t bus;
  logic [DATA_W-1:0] rdata;
  dsc_ctl_t ctl;
  logic pass_out, pass_oe_n, irq;
  int fail_count = 0;
  int num_checks = 0;
  int k;

  dsc_top dsc_top_i (.mclk(mclk), .arst_n(arst_n), .pins(pin_w),
    .test_error(err_w), .pixel_mhz(pixel_mhz), .bus(bus), .rdata(rdata),
    .ctl(ctl), .pass_out(pass_out), .pass_oe_n(pass_oe_n), .irq(irq));
  dsc_link_model dsc_link_model_i (.mclk(mclk), .link_on(link_on),
    .inject_err(inject), .lock(lock_w), .err(err_w));

  always_comb begin
    pin_w = pin_r;
    pin_w.pll_lock = lock_w;
    pin_w.strap_level = pass_oe_n ? pin_r.strap_level : pass_out;
  end

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask : rd

  task automatic t_power;
    chk1(ctl.pll_enable, 1'b0);
    wr(OFS_CTRL, 8'h03);
    rd(OFS_CTRL, 8'h00);
    pin_r.strap_level <= 1'b1;
    pin_r.power_down_n <= 1'b1;
    tick(8);
    chk1(ctl.pll_enable, 1'b1);
    chk1(ctl.input_gain_boost, 1'b1);
    rd(OFS_ISTAT, 8'h08);
    pin_r.strap_level <= 1'b0;
    tick(6);
    chk1(ctl.input_gain_boost, 1'b1);
  endtask : t_power

  task automatic t_fields(input logic [7:0] c, input logic p,
                          input logic [2:0] e);
    wr(OFS_CTRL, c);
    pin_r.output_swing_select <= p;
    pin_r.low_band_select <= p;
    pin_r.bit_order_select <= p;
    tick(6);
    chk1(ctl.swing_large, e[0]);
    chk1(ctl.low_band_setting, e[1]);
    chk1(ctl.msb_on_lane_three, e[2]);
  endtask : t_fields

  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      pin_r.mode_pins <= 2'(m);
      tick(6);
      chk8(8'(ctl.mode), 8'(m));
      chk1(ctl.ctl_filter, m == 1);
    end
    wr(OFS_CTRL, 8'hC0);
    pin_r.mode_pins <= 2'b10;
    tick(6);
    chk8(8'(ctl.mode), 8'(MODE_LEGACY_A));
    chk1(ctl.ctl_filter, 1'b0);
    pin_r.mode_pins <= 2'b00;
    tick(6);
    chk8(8'(ctl.mode), 8'(MODE_NATIVE_FILT));
    wr(OFS_CTRL, 8'h00);
  endtask : t_mode

  task automatic t_lanes;
    link_on <= 1'b1;
    pin_r.output_enable_pin <= 1'b1;
    for (k = 0; k < 30 && ctl.lock !== 1'b1; k++) tick(1);
    if (k == 30) begin
      fail_count++;
      end_sim();
    end
    tick(1);
    chk1(ctl.lanes_data, 1'b1);
    chk1(ctl.lock, 1'b1);
    pin_r.output_enable_pin <= 1'b0;
    tick(6);
    chk1(ctl.lanes_data, 1'b0);
    chk1(ctl.lanes_drive, 1'b0);
    link_on <= 1'b0;
    pin_r.output_enable_pin <= 1'b1;
    pin_r.sleep_state_select <= 1'b1;
    tick(8);
    chk1(ctl.lanes_data, 1'b0);
    chk1(ctl.lock, 1'b0);
    chk1(ctl.lanes_drive, 1'b1);
    pin_r.sleep_state_select <= 1'b0;
    tick(6);
    chk1(ctl.lanes_drive, 1'b0);
  endtask : t_lanes

  task automatic t_ssc;
    pin_r.spread_range_select <= 3'h5;
    pixel_mhz <= 8'h41;
    tick(6);
    chk1(ctl.ssc_enable, 1'b1);
    chk8(8'(ctl.spread_range), 8'h05);
    pixel_mhz <= 8'h42;
    tick(3);
    chk1(ctl.ssc_enable, 1'b0);
    wr(OFS_RANGE, 8'h0A);
    tick(2);
    chk8(8'(ctl.spread_range), 8'h02);
  endtask : t_ssc

  task automatic t_test;
    wr(OFS_ISTAT, 8'h0F);
    wr(OFS_IMASK, 8'h04);
    pin_r.self_test_enable <= 1'b1;
    for (k = 0; k < 30 && pass_oe_n !== 1'b0; k++) tick(1);
    if (k == 30) begin
      fail_count++;
      end_sim();
    end
    chk1(pass_out, 1'b1);
    chk1(ctl.self_test_active, 1'b1);
    chk1(irq, 1'b0);
    rd(OFS_STAT, 8'hE2);
    @(posedge mclk);
    inject <= 1'b1;
    @(posedge mclk);
    inject <= 1'b0;
    // Clear the error bit in the very cycle its event lands
    bus.addr <= OFS_ISTAT;
    bus.wdata <= 8'h04;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    tick(4);
    chk1(pass_out, 1'b0);
    chk1(irq, 1'b1);
    wr(OFS_IMASK, 8'h00);
    tick(2);
    chk1(irq, 1'b0);
    wr(OFS_IMASK, 8'h04);
    wr(OFS_ISTAT, 8'h04);
    tick(2);
    chk1(irq, 1'b0);
    pin_r.self_test_enable <= 1'b0;
    tick(6);
    chk1(pass_oe_n, 1'b1);
  endtask : t_test

  task automatic t_pd;
    wr(OFS_CTRL, 8'h01);
    pin_r.power_down_n <= 1'b0;
    pin_r.output_enable_pin <= 1'b1;
    pin_r.sleep_state_select <= 1'b1;
    tick(6);
    chk1(ctl.pll_enable, 1'b0);
    chk1(ctl.lanes_drive, 1'b0);
    pin_r.power_down_n <= 1'b1;
    tick(8);
    rd(OFS_CTRL, 8'h00);
    rd(OFS_RANGE, 8'h00);
    chk1(ctl.input_gain_boost, 1'b0);
  endtask : t_pd

  initial begin
    arst_n = 1'b0;
    pin_r = '0;
    bus = '0;
    pixel_mhz = 8'h28;
    link_on = 1'b0;
    inject = 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    tick(3);
    t_power();
    t_fields(8'h00, 1'b1, 3'h7);
    t_fields(8'h15, 1'b1, 3'h0);
    t_fields(8'h2A, 1'b0, 3'h0);
    t_fields(8'h3F, 1'b0, 3'h7);
    wr(OFS_CTRL, 8'h00);
    t_mode();
    t_lanes();
    t_ssc();
    t_test();
    t_pd();
    end_sim();
  end

  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : test_deser_control_config
`default_nettype wire
